/* include/pdr_pkg.sv */
// package for the data area bank router: area codes, operations, limits
// assumes a single controller clock and an instruction sequencer on the request side
package pdr_pkg;
   localparam int LINK_WORDS      = 64;
   localparam int TEMP_BITS       = 8;
   localparam int BANK_WORDS      = 6144;
   localparam int MAX_BANKS       = 3;
   localparam logic [13:0] SIO_LO      = 14'h03E8;   // 1000
   localparam logic [13:0] SIO_HI      = 14'h0A27;   // 2599
   localparam logic [13:0] SIO_REL_LO  = 14'h1B58;   // 7000
   localparam logic [13:0] SIO_REL_HI  = 14'h2197;   // 8599
   localparam logic [13:0] RSV_LO      = 14'h1770;   // 6000
   localparam logic [13:0] RSV_HI      = 14'h1B57;   // 6999
   localparam logic [13:0] EXP_LO      = 14'h1B58;   // 7000
   localparam logic [13:0] EXP_HI      = 14'h270F;   // 9999
   localparam logic [7:0]  IDS_NORMAL  = 8'h00;      // switch operand 000
   localparam logic [1:0]  BANK_RESET  = 2'h0;
   localparam logic [15:0] USER_MEM_DEFAULT = 16'h7CE0; // words of program space

   typedef enum logic [2:0] {
      PDR_AREA_LINK, PDR_AREA_NORMAL, PDR_AREA_TEMP, PDR_AREA_EXT, PDR_AREA_INDIRECT
   } pdr_area_t;

   typedef enum logic [2:0] {
      PDR_OP_NONE, PDR_OP_READ, PDR_OP_WRITE, PDR_OP_BANK_CHANGE,
      PDR_OP_CUR_XFER, PDR_OP_EXP_XFER, PDR_OP_IND_SWITCH
   } pdr_op_t;

   typedef struct packed {
      pdr_op_t   op;
      pdr_area_t area;
      logic      bit_mode;
      logic [3:0]  bit_sel;
      logic [13:0] addr;
      logic [1:0]  bank;
      logic [7:0]  operand;
      logic        copy_path;
   } pdr_req_t;

   typedef struct packed {
      logic        valid;
      pdr_area_t   area;
      logic [1:0]  bank;
      logic [13:0] addr;
      logic        write;
      logic        bit_mode;
      logic [3:0]  bit_sel;
   } pdr_mem_t;
endpackage : pdr_pkg

/* hdl/pdr_router.sv */
// data area router: decodes operand accesses into memory array selects
// assumes requests are single-cycle pulses synchronous to clk_i
module pdr_router #(
   parameter int NUM_BANKS = pdr_pkg::MAX_BANKS
) (
   input  wire logic              clk_i,          // controller clock
   input  wire logic              rst_n_i,        // power-on reset
   input  wire pdr_pkg::pdr_req_t req_i,          // sequencer request
   input  wire logic [15:0]       ptr_word_i,     // indirect pointer contents
   input  wire logic [15:0]       wdata_i,        // write data
   input  wire logic [63:0]       own_words_i,    // own link write-word map
   input  wire logic              sio_reloc_i,    // setup relocates special region
   input  wire logic              scan_start_i,   // scan cycle start pulse
   input  wire logic              irq_enter_i,    // interrupt routine entry
   input  wire logic              irq_return_i,   // interrupt routine return
   input  wire logic              edit_mode_i,    // program-edit mode entry
   input  wire logic              il_reset_i,     // interlock reset of link words
   input  wire logic              alloc_we_i,     // allocation update strobe
   input  wire logic [15:0]       alloc_exp_i,    // words for expansion memory
   input  wire logic [15:0]       alloc_cmt_i,    // words for comment area
   input  wire logic              peer_we_i,      // peer word arrival
   input  wire logic [5:0]        peer_addr_i,    // peer word address
   input  wire logic [15:0]       peer_data_i,    // peer word data
   output pdr_pkg::pdr_mem_t      mem_o,          // routed memory select
   output logic [15:0]            rdata_o,        // link/temp read data
   output logic [15:0]            link_tx_data_o, // own word sent to peers
   output logic [5:0]             link_tx_addr_o, // own word address to peers
   output logic                   link_tx_o,      // own word send pulse
   output logic [1:0]             cur_bank_o,     // current bank
   output logic                   ind_ext_o,      // indirect targets a bank
   output logic [1:0]             ind_bank_o,     // indirect bank
   output logic [15:0]            prog_words_o,   // program space remaining
   output logic                   refuse_o,       // access refused pulse
   output logic                   bank_err_o      // bad bank pulse
);
   logic [15:0] link_reg [pdr_pkg::LINK_WORDS];
   logic [15:0] link_next [pdr_pkg::LINK_WORDS];
   logic [pdr_pkg::TEMP_BITS-1:0] temp_reg, temp_next;
   logic [1:0]  bank_reg, bank_next;
   logic        ind_ext_reg, ind_ext_next, sav_ext_reg, sav_ext_next;
   logic [1:0]  ind_bank_reg, ind_bank_next, sav_bank_reg, sav_bank_next;
   logic [15:0] exp_reg, exp_next, cmt_reg, cmt_next, prog_reg, prog_next;
   pdr_pkg::pdr_mem_t mem_reg, mem_next;
   logic [15:0] rdata_reg, rdata_next, tx_data_reg, tx_data_next;
   logic [5:0]  tx_addr_reg, tx_addr_next;
   logic        tx_reg, tx_next, refuse_reg, refuse_next, berr_reg, berr_next;
   logic        bank_ok, link_clear, is_w;
   logic [5:0]  laddr;

   always_comb begin
      bank_ok    = (req_i.bank < 2'(NUM_BANKS));
      link_clear = edit_mode_i | il_reset_i;
      is_w       = (req_i.op == pdr_pkg::PDR_OP_WRITE);
      laddr      = req_i.addr[5:0];
      link_next  = link_reg;
      temp_next  = temp_reg;
      bank_next  = bank_reg;
      ind_ext_next  = ind_ext_reg;
      ind_bank_next = ind_bank_reg;
      sav_ext_next  = sav_ext_reg;
      sav_bank_next = sav_bank_reg;
      exp_next   = exp_reg;
      cmt_next   = cmt_reg;
      mem_next   = '0;
      rdata_next = rdata_reg;
      tx_data_next = tx_data_reg;
      tx_addr_next = tx_addr_reg;
      tx_next    = 1'b0;
      refuse_next = 1'b0;
      berr_next  = 1'b0;
      if (alloc_we_i) begin
         exp_next = alloc_exp_i;
         cmt_next = alloc_cmt_i;
      end
      prog_next = pdr_pkg::USER_MEM_DEFAULT - exp_next - cmt_next;
      if (peer_we_i && !own_words_i[peer_addr_i])
         link_next[peer_addr_i] = peer_data_i;
      case (req_i.op)
         pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_OP_WRITE: begin
            case (req_i.area)
               pdr_pkg::PDR_AREA_LINK: begin
                  if (req_i.addr >= 14'(pdr_pkg::LINK_WORDS)) begin
                     refuse_next = 1'b1;
                  end else if (is_w && !own_words_i[laddr]) begin
                     refuse_next = 1'b1;
                  end else if (is_w) begin
                     if (req_i.bit_mode)
                        link_next[laddr][req_i.bit_sel] = wdata_i[0];
                     else
                        link_next[laddr] = wdata_i;
                     tx_next      = 1'b1;
                     tx_addr_next = laddr;
                     tx_data_next = link_next[laddr];
                  end else begin
                     rdata_next = req_i.bit_mode ?
                        {15'h0000, link_reg[laddr][req_i.bit_sel]} : link_reg[laddr];
                  end
               end
               pdr_pkg::PDR_AREA_TEMP: begin
                  if (req_i.addr >= 14'(pdr_pkg::TEMP_BITS)) begin
                     refuse_next = 1'b1;
                  end else if (is_w) begin
                     temp_next[req_i.addr[2:0]] = wdata_i[0];
                  end else begin
                     rdata_next = {15'h0000, temp_reg[req_i.addr[2:0]]};
                  end
               end
               pdr_pkg::PDR_AREA_NORMAL: begin
                  if (req_i.bit_mode)
                     refuse_next = 1'b1;
                  else if (req_i.addr >= pdr_pkg::RSV_LO && req_i.addr <= pdr_pkg::RSV_HI)
                     refuse_next = 1'b1;
                  else if (!sio_reloc_i && req_i.addr >= pdr_pkg::SIO_LO
                           && req_i.addr <= pdr_pkg::SIO_HI)
                     refuse_next = 1'b1;
                  else if (sio_reloc_i && req_i.addr >= pdr_pkg::SIO_REL_LO
                           && req_i.addr <= pdr_pkg::SIO_REL_HI)
                     refuse_next = 1'b1;
                  else if (req_i.addr >= pdr_pkg::EXP_LO && req_i.addr <= pdr_pkg::EXP_HI
                           && (!req_i.copy_path || is_w))
                     refuse_next = 1'b1;
                  else if (req_i.addr > pdr_pkg::EXP_HI)
                     refuse_next = 1'b1;
                  else
                     mem_next = '{1'b1, pdr_pkg::PDR_AREA_NORMAL, 2'h0, req_i.addr,
                                  is_w, 1'b0, 4'h0};
               end
               pdr_pkg::PDR_AREA_INDIRECT: begin
                  if (ind_ext_reg) begin
                     if (ptr_word_i >= 16'(pdr_pkg::BANK_WORDS))
                        refuse_next = 1'b1;
                     else
                        mem_next = '{1'b1, pdr_pkg::PDR_AREA_EXT, ind_bank_reg,
                                     ptr_word_i[13:0], is_w, 1'b0, 4'h0};
                  end else begin
                     mem_next = '{1'b1, pdr_pkg::PDR_AREA_NORMAL, 2'h0,
                                  ptr_word_i[13:0], is_w, 1'b0, 4'h0};
                  end
               end
               default: refuse_next = 1'b1;  // banks only by transfer ops or switched indirect
            endcase
         end
         pdr_pkg::PDR_OP_BANK_CHANGE: begin
            if (bank_ok) bank_next = req_i.bank;
            else berr_next = 1'b1;
         end
         pdr_pkg::PDR_OP_CUR_XFER: begin
            if (req_i.addr >= 14'(pdr_pkg::BANK_WORDS)) refuse_next = 1'b1;
            else mem_next = '{1'b1, pdr_pkg::PDR_AREA_EXT, bank_reg, req_i.addr,
                              req_i.copy_path, 1'b0, 4'h0};
         end
         pdr_pkg::PDR_OP_EXP_XFER: begin
            if (!bank_ok) berr_next = 1'b1;
            else if (req_i.addr >= 14'(pdr_pkg::BANK_WORDS)) refuse_next = 1'b1;
            else mem_next = '{1'b1, pdr_pkg::PDR_AREA_EXT, req_i.bank, req_i.addr,
                              req_i.copy_path, 1'b0, 4'h0};
         end
         pdr_pkg::PDR_OP_IND_SWITCH: begin
            if (req_i.operand == pdr_pkg::IDS_NORMAL) begin
               ind_ext_next = 1'b0;
            end else if (!bank_ok) begin
               berr_next = 1'b1;
            end else begin
               ind_ext_next  = 1'b1;
               ind_bank_next = req_i.bank;
               bank_next     = req_i.bank;
            end
         end
         default: ;
      endcase
      if (irq_enter_i) begin
         sav_ext_next  = ind_ext_reg;
         sav_bank_next = ind_bank_reg;
         ind_ext_next  = 1'b0;
      end
      if (irq_return_i) begin
         ind_ext_next  = sav_ext_reg;
         ind_bank_next = sav_bank_reg;
      end
      if (scan_start_i) ind_ext_next = 1'b0;
      if (link_clear) begin
         for (int i = 0; i < pdr_pkg::LINK_WORDS; i++) link_next[i] = 16'h0000;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < pdr_pkg::LINK_WORDS; i++) link_reg[i] <= 16'h0000;
         temp_reg     <= '0;
         bank_reg     <= pdr_pkg::BANK_RESET;
         ind_ext_reg  <= 1'b0;
         ind_bank_reg <= 2'h0;
         sav_ext_reg  <= 1'b0;
         sav_bank_reg <= 2'h0;
         exp_reg      <= 16'h0000;
         cmt_reg      <= 16'h0000;
         prog_reg     <= pdr_pkg::USER_MEM_DEFAULT;
         mem_reg      <= '0;
         rdata_reg    <= 16'h0000;
         tx_data_reg  <= 16'h0000;
         tx_addr_reg  <= 6'h00;
         tx_reg       <= 1'b0;
         refuse_reg   <= 1'b0;
         berr_reg     <= 1'b0;
      end else begin
         link_reg     <= link_next;
         temp_reg     <= temp_next;
         bank_reg     <= bank_next;
         ind_ext_reg  <= ind_ext_next;
         ind_bank_reg <= ind_bank_next;
         sav_ext_reg  <= sav_ext_next;
         sav_bank_reg <= sav_bank_next;
         exp_reg      <= exp_next;
         cmt_reg      <= cmt_next;
         prog_reg     <= prog_next;
         mem_reg      <= mem_next;
         rdata_reg    <= rdata_next;
         tx_data_reg  <= tx_data_next;
         tx_addr_reg  <= tx_addr_next;
         tx_reg       <= tx_next;
         refuse_reg   <= refuse_next;
         berr_reg     <= berr_next;
      end
   end

   assign mem_o          = mem_reg;
   assign rdata_o        = rdata_reg;
   assign link_tx_data_o = tx_data_reg;
   assign link_tx_addr_o = tx_addr_reg;
   assign link_tx_o      = tx_reg;
   assign cur_bank_o     = bank_reg;
   assign ind_ext_o      = ind_ext_reg;
   assign ind_bank_o     = ind_bank_reg;
   assign prog_words_o   = prog_reg;
   assign refuse_o       = refuse_reg;
   assign bank_err_o     = berr_reg;

   a_link_write_own: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (req_i.op == pdr_pkg::PDR_OP_WRITE && req_i.area == pdr_pkg::PDR_AREA_LINK
       && !own_words_i[req_i.addr[5:0]]) |=> refuse_o && !link_tx_o)
      else $error("link write to foreign word");
   a_bank_reset_zero: assert property (@(posedge clk_i)
      $rose(rst_n_i) |-> cur_bank_o == 2'h0) else $error("bank not zero after reset");
   a_bank_in_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cur_bank_o < 2'(NUM_BANKS)) else $error("current bank out of range");
   a_scan_restore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      scan_start_i |=> !ind_ext_o) else $error("indirect not normal after scan start");
   a_irq_enter_norm: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (irq_enter_i && !irq_return_i && !scan_start_i) |=> !ind_ext_o)
      else $error("indirect not normal in interrupt");
   a_irq_return_rest: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (irq_return_i && !scan_start_i) |=> {ind_ext_o, ind_bank_o} == $past({sav_ext_reg, sav_bank_reg}))
      else $error("indirect not restored on return");
   a_bank_held_scan: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (scan_start_i && req_i.op == pdr_pkg::PDR_OP_NONE) |=> $stable(cur_bank_o))
      else $error("bank changed at scan start");
   a_bad_bank_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (req_i.op == pdr_pkg::PDR_OP_BANK_CHANGE && req_i.bank >= 2'(NUM_BANKS))
      |=> bank_err_o && $stable(cur_bank_o)) else $error("bad bank not flagged");
   a_normal_bit_refuse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (req_i.op == pdr_pkg::PDR_OP_READ && req_i.area == pdr_pkg::PDR_AREA_NORMAL
       && req_i.bit_mode) |=> refuse_o && !mem_o.valid) else $error("bit access to normal");
   a_sio_reserved: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (req_i.op == pdr_pkg::PDR_OP_READ && req_i.area == pdr_pkg::PDR_AREA_NORMAL
       && !sio_reloc_i && req_i.addr >= pdr_pkg::SIO_LO && req_i.addr <= pdr_pkg::SIO_HI)
      |=> refuse_o) else $error("special region not reserved");
   a_ind_switch_norm: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (req_i.op == pdr_pkg::PDR_OP_IND_SWITCH && req_i.operand == pdr_pkg::IDS_NORMAL
       && !irq_return_i) |=> !ind_ext_o) else $error("indirect not returned to normal");
   a_exp_xfer_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (req_i.op == pdr_pkg::PDR_OP_EXP_XFER) |=> $stable(cur_bank_o))
      else $error("explicit transfer moved current bank");
   a_cur_xfer_bank: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (req_i.op == pdr_pkg::PDR_OP_CUR_XFER && req_i.addr < 14'(pdr_pkg::BANK_WORDS))
      |=> mem_o.valid && mem_o.bank == $past(cur_bank_o))
      else $error("transfer not in current bank");
   a_link_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      edit_mode_i ##1 (!peer_we_i && req_i.op == pdr_pkg::PDR_OP_NONE)
      ##1 (req_i.op == pdr_pkg::PDR_OP_READ && req_i.area == pdr_pkg::PDR_AREA_LINK
       && !req_i.bit_mode && req_i.addr < 14'h0040 && !peer_we_i)
      |=> rdata_o == 16'h0000)
      else $error("link not cleared");
endmodule : pdr_router

/* sim/pdr_peer_link.sv */
// behavioural model of a peer controller on the shared link area
// assumes the router under test on the same controller clock
module pdr_peer_link (
   input  wire logic        clk_i,           // controller clock
   input  wire logic        link_tx_i,       // own word send pulse from router
   input  wire logic [5:0]  link_tx_addr_i,  // own word address from router
   input  wire logic [15:0] link_tx_data_i,  // own word data from router
   output logic             peer_we_o,       // peer word arrival pulse
   output logic [5:0]       peer_addr_o,     // peer word address
   output logic [15:0]      peer_data_o      // peer word data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rx_word_reg;
   logic [5:0]  rx_addr_reg;
   int          rx_count;

   initial begin
      peer_we_o   = 1'b0;
      peer_addr_o = 6'h00;
      peer_data_o = 16'h0000;
      rx_count    = 0;
   end

   // the peer keeps only the last word this controller sent, with its word number
   always @(posedge clk_i) begin
      if (link_tx_i) begin
         rx_word_reg <= link_tx_data_i;
         rx_addr_reg <= link_tx_addr_i;
         rx_count    <= rx_count + 1;
      end
   end

   // one peer write word, delivered at its own word number; data inverted afterwards
   task automatic send(input logic [5:0] addr, input logic [15:0] data);
      @(posedge clk_i);
      #2;
      peer_we_o   = 1'b1;
      peer_addr_o = addr;
      peer_data_o = data;
      @(posedge clk_i);
      #2;
      peer_we_o   = 1'b0;
      peer_addr_o = ~addr;
      peer_data_o = ~data;
   endtask : send
endmodule : pdr_peer_link

/* sim/tb_pdr_router.sv */
// self-checking bench for the data area router
// assumes the peer link model beside the router and one 40 MHz clock
module tb_pdr_router;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, (got), (exp)); end end
   logic clk_i, rst_n_i, scan_start_i, irq_enter_i, irq_return_i, edit_mode_i, il_reset_i;
   logic sio_reloc_i, alloc_we_i, peer_we_i, link_tx_o, ind_ext_o, refuse_o, bank_err_o;
   logic [15:0] ptr_word_i, wdata_i, alloc_exp_i, alloc_cmt_i, peer_data_i, rdata_o;
   logic [15:0] link_tx_data_o, prog_words_o;
   logic [63:0] own_words_i;
   logic [5:0]  peer_addr_i, link_tx_addr_o;
   logic [1:0]  cur_bank_o, ind_bank_o;
   pdr_pkg::pdr_req_t req_i;
   pdr_pkg::pdr_mem_t mem_o;
   int miscompares, total_checks, cycles;

   pdr_router #(.NUM_BANKS(3)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
      .ptr_word_i(ptr_word_i), .wdata_i(wdata_i), .own_words_i(own_words_i),
      .sio_reloc_i(sio_reloc_i), .scan_start_i(scan_start_i), .irq_enter_i(irq_enter_i),
      .irq_return_i(irq_return_i), .edit_mode_i(edit_mode_i), .il_reset_i(il_reset_i),
      .alloc_we_i(alloc_we_i), .alloc_exp_i(alloc_exp_i), .alloc_cmt_i(alloc_cmt_i),
      .peer_we_i(peer_we_i), .peer_addr_i(peer_addr_i), .peer_data_i(peer_data_i),
      .mem_o(mem_o), .rdata_o(rdata_o), .link_tx_data_o(link_tx_data_o),
      .link_tx_addr_o(link_tx_addr_o), .link_tx_o(link_tx_o), .cur_bank_o(cur_bank_o),
      .ind_ext_o(ind_ext_o), .ind_bank_o(ind_bank_o), .prog_words_o(prog_words_o),
      .refuse_o(refuse_o), .bank_err_o(bank_err_o));
   pdr_peer_link peer (.clk_i(clk_i), .link_tx_i(link_tx_o), .link_tx_addr_i(link_tx_addr_o),
      .link_tx_data_i(link_tx_data_o), .peer_we_o(peer_we_i), .peer_addr_o(peer_addr_i),
      .peer_data_o(peer_data_i));

   function automatic pdr_pkg::pdr_req_t mk(input pdr_pkg::pdr_op_t op,
      input pdr_pkg::pdr_area_t area, input logic [13:0] addr, input logic [1:0] bank,
      input logic [7:0] operand, input logic copy);
      pdr_pkg::pdr_req_t r;
      r = '0;
      r.op = op; r.area = area; r.addr = addr; r.bank = bank;
      r.operand = operand; r.copy_path = copy;
      return r;
   endfunction : mk

   // one request cycle; outputs are looked at in the cycle after the taking edge
   task automatic step(input pdr_pkg::pdr_req_t r);
      @(posedge clk_i);
      #2;
      req_i = r;
      @(posedge clk_i);
      #2;
      req_i = '0;
   endtask : step

   // pulses {scan, irq enter, irq return, edit, interlock reset}
   task automatic ctl(input logic [4:0] m);
      @(posedge clk_i);
      #2;
      {scan_start_i, irq_enter_i, irq_return_i, edit_mode_i, il_reset_i} = m;
      @(posedge clk_i);
      #2;
      {scan_start_i, irq_enter_i, irq_return_i, edit_mode_i, il_reset_i} = 5'h00;
   endtask : ctl

   task automatic t_bank;
      `CHK(cur_bank_o, 2'h0)
      step(mk(pdr_pkg::PDR_OP_BANK_CHANGE, pdr_pkg::PDR_AREA_EXT, 14'h0000, 2'h1, 8'h00, 0));
      `CHK(cur_bank_o, 2'h1)
      step(mk(pdr_pkg::PDR_OP_BANK_CHANGE, pdr_pkg::PDR_AREA_EXT, 14'h0000, 2'h3, 8'h00, 0));
      `CHK(bank_err_o, 1'b1)
      `CHK(cur_bank_o, 2'h1)
      step(mk(pdr_pkg::PDR_OP_CUR_XFER, pdr_pkg::PDR_AREA_EXT, 14'h17FF, 2'h0, 8'h00, 0));
      `CHK({mem_o.valid, mem_o.area, mem_o.bank, mem_o.addr},
           {1'b1, pdr_pkg::PDR_AREA_EXT, 2'h1, 14'h17FF})
      step(mk(pdr_pkg::PDR_OP_CUR_XFER, pdr_pkg::PDR_AREA_EXT, 14'h1800, 2'h0, 8'h00, 0));
      `CHK({refuse_o, mem_o.valid}, 2'b10)
      step(mk(pdr_pkg::PDR_OP_EXP_XFER, pdr_pkg::PDR_AREA_EXT, 14'h0010, 2'h2, 8'h00, 0));
      `CHK({mem_o.valid, mem_o.bank, cur_bank_o}, {1'b1, 2'h2, 2'h1})
      ctl(5'h10);
      ctl(5'h08);
      ctl(5'h04);
      `CHK(cur_bank_o, 2'h1)
      $display("test bank done");
   endtask : t_bank

   task automatic t_ind;
      step(mk(pdr_pkg::PDR_OP_IND_SWITCH, pdr_pkg::PDR_AREA_EXT, 14'h0000, 2'h2, 8'h01, 0));
      `CHK({ind_ext_o, ind_bank_o, cur_bank_o}, {1'b1, 2'h2, 2'h2})
      ptr_word_i = 16'h0100;
      step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_INDIRECT, 14'h0000, 2'h0, 8'h00, 0));
      `CHK({mem_o.valid, mem_o.area, mem_o.bank, mem_o.addr},
           {1'b1, pdr_pkg::PDR_AREA_EXT, 2'h2, 14'h0100})
      ctl(5'h08);
      `CHK(ind_ext_o, 1'b0)
      ctl(5'h04);
      `CHK(ind_ext_o, 1'b1)
      ctl(5'h10);
      `CHK(ind_ext_o, 1'b0)
      step(mk(pdr_pkg::PDR_OP_IND_SWITCH, pdr_pkg::PDR_AREA_EXT, 14'h0000, 2'h1, 8'h01, 0));
      step(mk(pdr_pkg::PDR_OP_IND_SWITCH, pdr_pkg::PDR_AREA_EXT, 14'h0000, 2'h0,
              pdr_pkg::IDS_NORMAL, 0));
      `CHK({ind_ext_o, cur_bank_o}, {1'b0, 2'h1})
      $display("test indirect done");
   endtask : t_ind

   task automatic t_link;
      pdr_pkg::pdr_req_t r;
      own_words_i = 64'h0000_0000_0000_0020;
      wdata_i = 16'h1234;
      step(mk(pdr_pkg::PDR_OP_WRITE, pdr_pkg::PDR_AREA_LINK, 14'h0005, 2'h0, 8'h00, 0));
      `CHK({link_tx_o, link_tx_addr_o, link_tx_data_o}, {1'b1, 6'h05, 16'h1234})
      r = mk(pdr_pkg::PDR_OP_WRITE, pdr_pkg::PDR_AREA_LINK, 14'h0005, 2'h0, 8'h00, 0);
      r.bit_mode = 1'b1;
      r.bit_sel = 4'hF;
      wdata_i = 16'h0001;
      step(r);
      `CHK(link_tx_data_o, 16'h9234)
      step(mk(pdr_pkg::PDR_OP_WRITE, pdr_pkg::PDR_AREA_LINK, 14'h0006, 2'h0, 8'h00, 0));
      `CHK({refuse_o, link_tx_o}, 2'b10)
      `CHK(peer.rx_count, 2)
      `CHK({peer.rx_addr_reg, peer.rx_word_reg}, {6'h05, 16'h9234})
      step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_LINK, 14'h0040, 2'h0, 8'h00, 0));
      `CHK(refuse_o, 1'b1)
      for (int k = 0; k < 2; k++) begin
         peer.send(6'h3F, 16'hA5C3);
         step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_LINK, 14'h003F, 2'h0, 8'h00, 0));
         `CHK(rdata_o, 16'hA5C3)
         ctl(k == 0 ? 5'h02 : 5'h01);
         step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_LINK, 14'h003F, 2'h0, 8'h00, 0));
         `CHK(rdata_o, 16'h0000)
      end
      $display("test link done");
   endtask : t_link

   task automatic t_areas;
      pdr_pkg::pdr_req_t r;
      step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_NORMAL, 14'h0064, 2'h0, 8'h00, 0));
      `CHK({mem_o.valid, mem_o.area, mem_o.addr},
           {1'b1, pdr_pkg::PDR_AREA_NORMAL, 14'h0064})
      r = mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_NORMAL, 14'h0064, 2'h0, 8'h00, 0);
      r.bit_mode = 1'b1;
      step(r);
      `CHK(refuse_o, 1'b1)
      step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_NORMAL, 14'h05DC, 2'h0, 8'h00, 0));
      `CHK(refuse_o, 1'b1)
      sio_reloc_i = 1'b1;
      step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_NORMAL, 14'h05DC, 2'h0, 8'h00, 0));
      `CHK({refuse_o, mem_o.valid}, 2'b01)
      step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_NORMAL, 14'h1964, 2'h0, 8'h00, 0));
      `CHK(refuse_o, 1'b1)
      step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_NORMAL, 14'h2328, 2'h0, 8'h00, 0));
      `CHK(refuse_o, 1'b1)
      step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_NORMAL, 14'h2328, 2'h0, 8'h00, 1));
      `CHK({refuse_o, mem_o.valid}, 2'b01)
      step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_TEMP, 14'h0008, 2'h0, 8'h00, 0));
      `CHK(refuse_o, 1'b1)
      wdata_i = 16'h0001;
      step(mk(pdr_pkg::PDR_OP_WRITE, pdr_pkg::PDR_AREA_TEMP, 14'h0007, 2'h0, 8'h00, 0));
      step(mk(pdr_pkg::PDR_OP_READ, pdr_pkg::PDR_AREA_TEMP, 14'h0007, 2'h0, 8'h00, 0));
      `CHK({refuse_o, rdata_o}, {1'b0, 16'h0001})
      `CHK(prog_words_o, pdr_pkg::USER_MEM_DEFAULT)
      @(posedge clk_i);
      #2;
      {alloc_we_i, alloc_exp_i, alloc_cmt_i} = {1'b1, 16'h0100, 16'h0020};
      @(posedge clk_i);
      #2;
      alloc_we_i = 1'b0;
      @(posedge clk_i);
      #2;
      `CHK(prog_words_o, pdr_pkg::USER_MEM_DEFAULT - 16'h0120)
      $display("test areas done");
   endtask : t_areas

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         wrap_up();
      end
   end

   initial begin
      {rst_n_i, scan_start_i, irq_enter_i, irq_return_i, edit_mode_i, il_reset_i} = '0;
      {sio_reloc_i, alloc_we_i, alloc_exp_i, alloc_cmt_i, ptr_word_i, wdata_i} = '0;
      own_words_i = '0;
      req_i = '0;
      {miscompares, total_checks, cycles} = '0;
      repeat (5) @(posedge clk_i);
      #2;
      rst_n_i = 1'b1;
      t_bank();
      t_ind();
      t_link();
      t_areas();
      wrap_up();
   end
endmodule : tb_pdr_router
